// ---- logic/cmt_timer.v ----
// Compare-match interval timer channel with Avalon-MM registers and interrupt
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "cmt_defines.vh"
module cmt_timer #(
  parameter CW = 16
) (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Avalon-MM slave
  input wire [`CMT_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Interrupt and event
  output reg irq,
  output reg match_pulse
);
  wire wr_stb;
  wire rd_stb;
  wire [`CMT_ADDR_W-1:0] reg_addr;
  wire [31:0] reg_wdata;
  wire [3:0] reg_be;
  reg [31:0] reg_rdata;

  // Control state
  reg count_start_bit_q;
  reg count_start_bit_d;
  reg clock_select_lo_q;
  reg clock_select_lo_d;
  reg clock_select_hi_q;
  reg clock_select_hi_d;
  reg irq_mask_q;
  reg irq_mask_d;

  // Timer state
  reg [CW-1:0] match_counter_q;
  reg [CW-1:0] match_counter_d;
  reg [CW-1:0] match_constant_q;
  reg [CW-1:0] match_constant_d;

  // Event state
  reg match_flag_q;
  reg match_flag_d;
  reg irq_status_q;
  reg irq_status_d;
  reg irq_d;
  reg match_pulse_d;

  // Count clock selection and compare
  wire [3:0] ticks;
  reg sel_tick;
  wire count_step;
  wire match;
  wire match_ev;

  // Register write decode
  wire lane0;
  wire lane1;
  reg wr_start;
  reg wr_ctrl;
  reg wr_cnt;
  reg wr_cor;
  reg wr_ist;
  reg wr_imask;

  cmt_avalon_slave #(
    .AW(`CMT_ADDR_W)
  ) u_bus (
    .mclk(mclk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .wr_stb(wr_stb),
    .rd_stb(),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_be(reg_be),
    .reg_rdata(reg_rdata)
  );

  // Four internal count clocks
  cmt_prescaler #(
    .DIV(`CMT_DIV0),
    .W(`CMT_DIV_W)
  ) u_pre0 (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(ticks[0])
  );

  cmt_prescaler #(
    .DIV(`CMT_DIV1),
    .W(`CMT_DIV_W)
  ) u_pre1 (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(ticks[1])
  );

  cmt_prescaler #(
    .DIV(`CMT_DIV2),
    .W(`CMT_DIV_W)
  ) u_pre2 (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(ticks[2])
  );

  cmt_prescaler #(
    .DIV(`CMT_DIV3),
    .W(`CMT_DIV_W)
  ) u_pre3 (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(ticks[3])
  );

  always @*
  begin
    case ({clock_select_hi_q, clock_select_lo_q})
      2'h0: sel_tick = ticks[0];
      2'h1: sel_tick = ticks[1];
      2'h2: sel_tick = ticks[2];
      default: sel_tick = ticks[3];
    endcase
  end

  // Byte lanes
  assign lane0 = reg_be[0];
  assign lane1 = reg_be[1];

  // Write strobes; single-byte registers need lane 0
  always @*
  begin
    wr_start = 1'b0;
    wr_ctrl = 1'b0;
    wr_cnt = 1'b0;
    wr_cor = 1'b0;
    wr_ist = 1'b0;
    wr_imask = 1'b0;
    if (wr_stb)
    begin
      if (reg_addr == `CMT_OFS_START)
        wr_start = lane0;
      else if (reg_addr == `CMT_OFS_CTRL)
        wr_ctrl = lane0;
      else if (reg_addr == `CMT_OFS_COUNTER)
        wr_cnt = 1'b1;
      else if (reg_addr == `CMT_OFS_CONSTANT)
        wr_cor = 1'b1;
      else if (reg_addr == `CMT_OFS_IRQ_STATUS)
        wr_ist = lane0;
      else if (reg_addr == `CMT_OFS_IRQ_MASK)
        wr_imask = lane0;
    end
  end

  // Start bit
  always @*
  begin
    count_start_bit_d = count_start_bit_q;
    if (wr_start)
      count_start_bit_d = reg_wdata[`CMT_BIT_START];
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      count_start_bit_q <= 1'b0;
    else
      count_start_bit_q <= count_start_bit_d;
  end

  // Count clock select
  always @*
  begin
    clock_select_lo_d = clock_select_lo_q;
    clock_select_hi_d = clock_select_hi_q;
    if (wr_ctrl)
    begin
      clock_select_lo_d = reg_wdata[`CMT_BIT_CKS_LO];
      clock_select_hi_d = reg_wdata[`CMT_BIT_CKS_HI];
    end
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clock_select_lo_q <= 1'b0;
      clock_select_hi_q <= 1'b0;
    end
    else
    begin
      clock_select_lo_q <= clock_select_lo_d;
      clock_select_hi_q <= clock_select_hi_d;
    end
  end

  // Interrupt mask
  always @*
  begin
    irq_mask_d = irq_mask_q;
    if (wr_imask)
      irq_mask_d = reg_wdata[`CMT_BIT_EV_MATCH];
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_mask_q <= 1'b0;
    else
      irq_mask_q <= irq_mask_d;
  end

  // One count step per selected tick while started
  assign count_step = count_start_bit_q & sel_tick;
  assign match = (match_counter_q == match_constant_q);
  // A counter write wins over counting and drops the match of that cycle
  assign match_ev = count_step & match & ~wr_cnt;

  // Counter
  always @*
  begin
    match_counter_d = match_counter_q;
    if (wr_cnt)
    begin
      if (lane0)
        match_counter_d[7:0] = reg_wdata[7:0];
      if (lane1)
        match_counter_d[15:8] = reg_wdata[15:8];
    end
    else if (count_step)
    begin
      if (match)
        match_counter_d = `CMT_ZERO16;
      else
        match_counter_d = match_counter_q + `CMT_ONE16;
    end
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      match_counter_q <= `CMT_COUNTER_RST;
    else
      match_counter_q <= match_counter_d;
  end

  // Constant register
  always @*
  begin
    match_constant_d = match_constant_q;
    if (wr_cor)
    begin
      if (lane0)
        match_constant_d[7:0] = reg_wdata[7:0];
      if (lane1)
        match_constant_d[15:8] = reg_wdata[15:8];
    end
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      match_constant_q <= `CMT_CONSTANT_RST;
    else
      match_constant_q <= match_constant_d;
  end

  // Match flag: setting beats the software clear
  always @*
  begin
    match_flag_d = match_flag_q;
    if (match_ev)
      match_flag_d = 1'b1;
    else if (wr_ctrl & ~reg_wdata[`CMT_BIT_FLAG])
      match_flag_d = 1'b0;
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      match_flag_q <= 1'b0;
    else
      match_flag_q <= match_flag_d;
  end

  // Sticky status: setting beats the write-one clear
  always @*
  begin
    irq_status_d = irq_status_q;
    if (match_ev)
      irq_status_d = 1'b1;
    else if (wr_ist & reg_wdata[`CMT_BIT_EV_MATCH])
      irq_status_d = 1'b0;
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_status_q <= 1'b0;
    else
      irq_status_q <= irq_status_d;
  end

  // Level interrupt and event pulse, both straight from flops
  always @*
  begin
    irq_d = irq_status_d & irq_mask_d;
    match_pulse_d = match_ev;
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq <= 1'b0;
      match_pulse <= 1'b0;
    end
    else
    begin
      irq <= irq_d;
      match_pulse <= match_pulse_d;
    end
  end

  // Read mux; unmapped reads return zero
  always @*
  begin
    reg_rdata = `CMT_UNMAPPED_DATA;
    if (reg_addr == `CMT_OFS_START)
      reg_rdata[`CMT_BIT_START] = count_start_bit_q;
    else if (reg_addr == `CMT_OFS_CTRL)
    begin
      reg_rdata[`CMT_BIT_CKS_LO] = clock_select_lo_q;
      reg_rdata[`CMT_BIT_CKS_HI] = clock_select_hi_q;
      reg_rdata[`CMT_BIT_FLAG] = match_flag_q;
    end
    else if (reg_addr == `CMT_OFS_COUNTER)
      reg_rdata[15:0] = match_counter_q;
    else if (reg_addr == `CMT_OFS_CONSTANT)
      reg_rdata[15:0] = match_constant_q;
    else if (reg_addr == `CMT_OFS_IRQ_STATUS)
      reg_rdata[`CMT_BIT_EV_MATCH] = irq_status_q;
    else if (reg_addr == `CMT_OFS_IRQ_MASK)
      reg_rdata[`CMT_BIT_EV_MATCH] = irq_mask_q;
  end
endmodule // cmt_timer

// ---- logic/cmt_defines.vh ----
// Register map, field positions, reset values and prescaler ratios of the match timer
`ifndef CMT_DEFINES_VH
`define CMT_DEFINES_VH

`define CMT_ADDR_W 4
`define CMT_OFS_START 4'h0
`define CMT_OFS_CTRL 4'h1
`define CMT_OFS_COUNTER 4'h2
`define CMT_OFS_CONSTANT 4'h3
`define CMT_OFS_IRQ_STATUS 4'h4
`define CMT_OFS_IRQ_MASK 4'h5

`define CMT_BIT_START 0
`define CMT_BIT_CKS_LO 0
`define CMT_BIT_CKS_HI 1
`define CMT_BIT_FLAG 7
`define CMT_BIT_EV_MATCH 0

`define CMT_COUNTER_RST 16'h0000
`define CMT_CONSTANT_RST 16'hFFFF
`define CMT_ZERO16 16'h0000
`define CMT_ONE16 16'h0001

`define CMT_DIV0 8
`define CMT_DIV1 32
`define CMT_DIV2 128
`define CMT_DIV3 512
`define CMT_DIV_W 10

`define CMT_UNMAPPED_DATA 32'h0000_0000

`endif

// ---- logic/cmt_prescaler.v ----
// Free-running divider that emits a one-cycle enable every DIV clocks
`timescale 1ns/1ps
`include "cmt_defines.vh"
module cmt_prescaler #(
  parameter DIV = `CMT_DIV0,
  parameter W = `CMT_DIV_W
) (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Enable pulse out
  output reg tick
);
  localparam [31:0] LAST_FULL = DIV - 1;
  localparam [W-1:0] LAST = LAST_FULL[W-1:0];
  reg [W-1:0] cnt_q;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= {W{1'b0}};
      tick <= 1'b0;
    end
    else
    begin
      tick <= (cnt_q == LAST);
      if (cnt_q == LAST)
        cnt_q <= {W{1'b0}};
      else
        cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // cmt_prescaler

// ---- logic/cmt_avalon_slave.v ----
// Avalon-MM slave front end: one-cycle waitrequest, registered read data
`timescale 1ns/1ps
`include "cmt_defines.vh"
module cmt_avalon_slave #(
  parameter AW = `CMT_ADDR_W
) (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Avalon-MM side
  input wire [AW-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Register file side
  output wire wr_stb,
  output wire rd_stb,
  output wire [AW-1:0] reg_addr,
  output wire [31:0] reg_wdata,
  output wire [3:0] reg_be,
  input wire [31:0] reg_rdata
);
  reg wait_q;
  wire req;
  wire ack;

  // Waitrequest is a flop: high while idle, low in the second cycle of a request
  assign req = avs_read | avs_write;
  assign ack = ~wait_q;
  assign avs_waitrequest = wait_q;
  assign wr_stb = avs_write & ack;
  assign rd_stb = avs_read & ack;
  assign reg_addr = avs_address;
  assign reg_wdata = avs_writedata;
  assign reg_be = avs_byteenable;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_q <= 1'b1;
      avs_readdata <= `CMT_UNMAPPED_DATA;
    end
    else
    begin
      wait_q <= ~(req & wait_q);
      // Captured in the first cycle, stands at the completing edge
      if (avs_read & wait_q)
        avs_readdata <= reg_rdata;
    end
  end
endmodule // cmt_avalon_slave

// ---- test/cmt_timer_asserts.sv ----
// Port assertions for the match timer
`timescale 1ns/1ps
module cmt_timer_asserts (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Bus
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Events
  input wire irq,
  input wire match_pulse
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_rd;
    avs_read && !avs_waitrequest;
  endsequence
  sequence s_mask_off;
    avs_write && !avs_waitrequest && avs_address == 4'h5 && avs_byteenable[0] && !avs_writedata[0];
  endsequence
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait cycle");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
  a_idle_wait: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
    else $error("ready while idle");
  a_unmapped_zero: assert property (s_rd ##0 (avs_address > 4'h5) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (s_rd ##0 (avs_address inside {4'h2, 4'h3}) |->
    avs_readdata[31:16] == 16'h0) else $error("upper bits set");
  a_pulse_single: assert property (match_pulse |=> !match_pulse)
    else $error("pulse too long");
  a_mask_clears: assert property (s_mask_off |-> ##2 !irq)
    else $error("masked irq high");
  a_irq_cause: assert property ($rose(irq) |-> match_pulse || $past(match_pulse) ||
    $past(match_pulse, 2) || $past(avs_write) || $past(avs_write, 2)) else $error("stray irq");
endmodule // cmt_timer_asserts

bind cmt_timer cmt_timer_asserts u_chk (.mclk, .rst_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .match_pulse);

// ---- test/cmt_timer_tb.sv ----
// Self-checking bench for the match timer
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("[ERR] %s exp %h got %h", n, e, g); \
    end \
  end
module cmt_timer_tb;
  reg mclk = 1'b0;
  reg rst_n = 1'b0;
  reg [3:0] a = 4'h0;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wd = 32'h0;
  reg [3:0] be = 4'hF;
  reg [31:0] q;
  wire [31:0] rdat;
  wire wait_r, irq, mp;
  int bad_count = 0;
  int cmp_count = 0;
  int n;
  always #10 mclk = ~mclk;
  cmt_timer u_dut (.mclk(mclk), .rst_n(rst_n), .avs_address(a), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wait_r),
    .irq(irq), .match_pulse(mp));
  task wrap_up;
    $display("Counts: %0d mismatches in %0d compares", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One bus cycle, held until waitrequest is seen low
  task xfer(input bit w, input [3:0] ad, input [31:0] d);
    int k;
    begin
      k = 0;
      @(posedge mclk);
      a <= ad;
      wd <= d;
      rd <= !w;
      wr <= w;
      do
      begin
        @(posedge mclk);
        k++;
      end while (wait_r !== 1'b0 && k < 50);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (k >= 50)
      begin
        bad_count++;
        wrap_up;
      end
    end
  endtask
  task wait_pulse;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (mp !== 1'b1 && n < 3000);
    if (n >= 3000)
    begin
      bad_count++;
      wrap_up;
    end
  endtask
  task t_reset;
    xfer(0, 4'h2, 0); `CHK("counter", 32'h0000_0000, q)
    xfer(0, 4'h3, 0); `CHK("constant", 32'h0000_FFFF, q)
    xfer(0, 4'h6, 0); `CHK("unmapped", 32'h0000_0000, q)
  endtask
  task t_stopped;
    repeat (600) @(posedge mclk);
    xfer(0, 4'h2, 0); `CHK("held", 32'h0000_0000, q)
    xfer(1, 4'h2, 32'h0000_1234);
    xfer(0, 4'h2, 0); `CHK("counter wr", 32'h0000_1234, q)
    xfer(1, 4'h3, 32'h0000_ABCD);
    xfer(0, 4'h3, 0); `CHK("constant wr", 32'h0000_ABCD, q)
  endtask
  task t_count;
    xfer(1, 4'h3, 32'h0000_0003);
    xfer(1, 4'h2, 32'h0000_0000);
    xfer(1, 4'h5, 32'h0000_0001);
    for (int s = 0; s < 4; s++)
    begin
      xfer(1, 4'h1, s);
      xfer(1, 4'h0, 32'h0000_0001);
      wait_pulse;
      wait_pulse;
      `CHK("interval", 4 * (8 << (2 * s)), n)
    end
    xfer(1, 4'h0, 32'h0000_0000);
    `CHK("irq", 1'b1, irq)
    xfer(0, 4'h1, 0); `CHK("flag", 1'b1, q[7])
    xfer(0, 4'h4, 0); `CHK("status", 1'b1, q[0])
    xfer(1, 4'h5, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    `CHK("masked", 1'b0, irq)
    xfer(1, 4'h5, 32'h0000_0001);
    xfer(1, 4'h4, 32'h0000_0001);
    xfer(1, 4'h1, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    `CHK("cleared", 1'b0, irq)
    xfer(0, 4'h1, 0); `CHK("flag clr", 1'b0, q[7])
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset;
    t_stopped;
    t_count;
    wrap_up;
  end
endmodule // cmt_timer_tb
